// ==== core/cltab_pkg.sv ====
/*
 * Shared constants for the comparator logic table array: counts, field
 * widths, reset values, the sixteen function codes and the destination
 * indices of the digital system interface routing.
 * Assumes one synchronous clock domain.
 */
// What this block does
// - Four independent tables, each with its own control word and output.
// - Each table maps two one-bit inputs, A and B, to one output bit.
// - Table inputs are comparator outputs, one comparator or two per table.
// - Every table output is driven onto the digital system interface.
// - The interface routes outputs to digital blocks, DMA, I/O or interrupts.
// - A 4-bit control word from software selects the function, from the clock edge that writes it.
// - Codes 0000b,1111b,0011b,0101b,1100b,1010b give 0, 1, A, B, ~A, ~B.
// - Codes 0001b,0010b,0100b,1110b give AND, A AND ~B, ~A AND B, NAND.
// - Codes 0111b,1000b,1011b,1101b,0110b,1001b: OR,NOR,A|~B,~A|B,XOR,XNOR.
package cltab_pkg;
    localparam int NUM_TABLES = 4;
    localparam int NUM_CMP = 4;
    localparam int NUM_DEST = 4;
    localparam int FUNC_W = 4;
    localparam int SYNC_STAGES = 2;

    localparam logic [FUNC_W-1:0] FUNC_RESET = 4'h0;

    localparam logic [FUNC_W-1:0] FN_FALSE = 4'h0;
    localparam logic [FUNC_W-1:0] FN_AND = 4'h1;
    localparam logic [FUNC_W-1:0] FN_A_ANDN_B = 4'h2;
    localparam logic [FUNC_W-1:0] FN_A = 4'h3;
    localparam logic [FUNC_W-1:0] FN_NA_AND_B = 4'h4;
    localparam logic [FUNC_W-1:0] FN_B = 4'h5;
    localparam logic [FUNC_W-1:0] FN_XOR = 4'h6;
    localparam logic [FUNC_W-1:0] FN_OR = 4'h7;
    localparam logic [FUNC_W-1:0] FN_NOR = 4'h8;
    localparam logic [FUNC_W-1:0] FN_XNOR = 4'h9;
    localparam logic [FUNC_W-1:0] FN_NOT_B = 4'hA;
    localparam logic [FUNC_W-1:0] FN_A_ORN_B = 4'hB;
    localparam logic [FUNC_W-1:0] FN_NOT_A = 4'hC;
    localparam logic [FUNC_W-1:0] FN_NA_OR_B = 4'hD;
    localparam logic [FUNC_W-1:0] FN_NAND = 4'hE;
    localparam logic [FUNC_W-1:0] FN_TRUE = 4'hF;

    // destination slots on the digital system interface
    localparam int DEST_PDB = 0;
    localparam int DEST_DMA = 1;
    localparam int DEST_IO = 2;
    localparam int DEST_IRQ = 3;
endpackage : cltab_pkg

// ==== core/cltab_unit.sv ====
/*
 * One comparator logic table: two inputs, one output, function chosen by
 * a 4-bit control word. Purely combinational.
 * Assumes the inputs are already synchronous to the caller's clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cltab_unit (
    input wire logic i_a,                             // table input A
    input wire logic i_b,                             // table input B
    input wire logic [cltab_pkg::FUNC_W-1:0] i_func,  // function code
    output logic o_y                                  // table output
);
    always_comb begin
        case (i_func)
            cltab_pkg::FN_FALSE: o_y = 1'b0;
            cltab_pkg::FN_TRUE: o_y = 1'b1;
            cltab_pkg::FN_A: o_y = i_a;
            cltab_pkg::FN_B: o_y = i_b;
            cltab_pkg::FN_NOT_A: o_y = ~i_a;
            cltab_pkg::FN_NOT_B: o_y = ~i_b;
            cltab_pkg::FN_AND: o_y = i_a & i_b;
            cltab_pkg::FN_A_ANDN_B: o_y = i_a & ~i_b;
            cltab_pkg::FN_NA_AND_B: o_y = ~i_a & i_b;
            cltab_pkg::FN_NAND: o_y = ~(i_a & i_b);
            cltab_pkg::FN_OR: o_y = i_a | i_b;
            cltab_pkg::FN_NOR: o_y = ~(i_a | i_b);
            cltab_pkg::FN_A_ORN_B: o_y = i_a | ~i_b;
            cltab_pkg::FN_NA_OR_B: o_y = ~i_a | i_b;
            cltab_pkg::FN_XOR: o_y = i_a ^ i_b;
            cltab_pkg::FN_XNOR: o_y = ~(i_a ^ i_b);
            default: o_y = 1'b0;
        endcase
    end
endmodule : cltab_unit
`default_nettype wire

// ==== core/cltab_array.sv ====
/*
 * Array of comparator logic tables with their control words, comparator
 * input selection and routing onto the digital system interface.
 * Assumes comparator outputs are asynchronous and that the configuration
 * port is driven from logic on i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cltab_array #(
    parameter int NUM_TABLES = cltab_pkg::NUM_TABLES,
    parameter int NUM_CMP = cltab_pkg::NUM_CMP
) (
    input wire logic i_core_clk,                        // system clock
    input wire logic i_reset,                           // sync reset, high
    input wire logic [NUM_CMP-1:0] i_cmp,               // comparator outs
    input wire logic i_cfg_we,                          // table cfg write
    input wire logic [$clog2(NUM_TABLES)-1:0] i_cfg_idx, // table index
    input wire logic [cltab_pkg::FUNC_W-1:0] i_cfg_func, // function code
    input wire logic [$clog2(NUM_CMP)-1:0] i_cfg_sel_a, // comparator for A
    input wire logic [$clog2(NUM_CMP)-1:0] i_cfg_sel_b, // comparator for B
    input wire logic i_route_we,                        // routing write
    input wire logic [1:0] i_route_dest,                // destination slot
    input wire logic [$clog2(NUM_TABLES)-1:0] i_route_table, // source table
    input wire logic i_route_en,                        // destination on
    output logic [NUM_TABLES-1:0] o_dsi,                // table outputs
    output logic [cltab_pkg::NUM_DEST-1:0] o_route,     // routed outputs
    output logic [NUM_TABLES*cltab_pkg::FUNC_W-1:0] o_func_words // readback
);
    localparam int IDX_W = $clog2(NUM_TABLES);
    localparam int SEL_W = $clog2(NUM_CMP);
    localparam int FW = cltab_pkg::FUNC_W;
    localparam int ND = cltab_pkg::NUM_DEST;

    // selects must address exactly the tables and comparators present
    if (NUM_TABLES < 2 || (1 << IDX_W) != NUM_TABLES) begin : g_chk_tab
        $error("NUM_TABLES must be a power of two, at least 2");
    end
    if (NUM_CMP < 2 || (1 << SEL_W) != NUM_CMP) begin : g_chk_cmp
        $error("NUM_CMP must be a power of two, at least 2");
    end
    if (ND != 4) begin : g_chk_dest
        $error("route_dest port is two bits, NUM_DEST must be 4");
    end

    logic [NUM_CMP-1:0] cmp_meta;
    logic [NUM_CMP-1:0] cmp_sync;
    logic [FW-1:0] func [NUM_TABLES];
    logic [SEL_W-1:0] sel_a [NUM_TABLES];
    logic [SEL_W-1:0] sel_b [NUM_TABLES];
    logic [IDX_W-1:0] route_table [ND];
    logic [ND-1:0] route_en;
    logic [NUM_TABLES-1:0] tab_a;
    logic [NUM_TABLES-1:0] tab_b;
    logic [NUM_TABLES-1:0] tab_out;

    // comparator outputs are analog-timed, so two flops first
    always_ff @(posedge i_core_clk) begin
        cmp_meta <= i_cmp;
        cmp_sync <= cmp_meta;
    end

    // control word write, one table per write
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int t = 0; t < NUM_TABLES; t++) begin
                func[t] <= cltab_pkg::FUNC_RESET;
            end
        end else if (i_cfg_we) begin
            func[i_cfg_idx] <= i_cfg_func;
        end
    end

    // per-input comparator choice, may name the same one twice
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int t = 0; t < NUM_TABLES; t++) begin
                sel_a[t] <= '0;
                sel_b[t] <= '0;
            end
        end else if (i_cfg_we) begin
            sel_a[i_cfg_idx] <= i_cfg_sel_a;
            sel_b[i_cfg_idx] <= i_cfg_sel_b;
        end
    end

    // destination routing table, all destinations off after reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            route_en <= '0;
            for (int d = 0; d < ND; d++) begin
                route_table[d] <= '0;
            end
        end else if (i_route_we) begin
            route_en[i_route_dest] <= i_route_en;
            route_table[i_route_dest] <= i_route_table;
        end
    end

    for (genvar t = 0; t < NUM_TABLES; t++) begin : g_tab
        assign tab_a[t] = cmp_sync[sel_a[t]];
        assign tab_b[t] = cmp_sync[sel_b[t]];

        // one independent table per control word
        cltab_unit u_unit (
            .i_a(tab_a[t]),
            .i_b(tab_b[t]),
            .i_func(func[t]),
            .o_y(tab_out[t])
        );

        // straight onto the interface, no added register
        assign o_dsi[t] = tab_out[t];
        assign o_func_words[t*FW +: FW] = func[t];
    end

    for (genvar d = 0; d < ND; d++) begin : g_route
        assign o_route[d] = route_en[d] & tab_out[route_table[d]];
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    for (genvar t = 0; t < NUM_TABLES; t++) begin : g_chk
        // truth table index: code bit {~A,~B} is the output
        reset_low_a: assert property (
            $past(i_reset) |-> (func[t] == cltab_pkg::FUNC_RESET)
                && !o_dsi[t])
            else $error("table not low after reset");

        func_write_a: assert property (
            (i_cfg_we && i_cfg_idx == IDX_W'(t))
                |=> func[t] == $past(i_cfg_func) && o_func_words[t*FW +: FW]
                == $past(i_cfg_func))
            else $error("control word write not taken");

        others_hold_a: assert property (
            (i_cfg_we && i_cfg_idx != IDX_W'(t)) |=> $stable(func[t]))
            else $error("write disturbed another table");

        const_codes_a: assert property (
            (func[t] == cltab_pkg::FN_FALSE |-> !o_dsi[t])
                and (func[t] == cltab_pkg::FN_TRUE |-> o_dsi[t])
                and (func[t] == cltab_pkg::FN_NOT_A |-> o_dsi[t] != tab_a[t]))
            else $error("constant or single-input code wrong");

        and_codes_a: assert property (
            (func[t] == cltab_pkg::FN_AND || func[t] == cltab_pkg::FN_NAND
                || func[t] == cltab_pkg::FN_A_ANDN_B
                || func[t] == cltab_pkg::FN_NA_AND_B)
                |-> o_dsi[t] == func[t][{~tab_a[t], ~tab_b[t]}])
            else $error("and-type code wrong");

        or_codes_a: assert property (
            o_dsi[t] == func[t][{~tab_a[t], ~tab_b[t]}])
            else $error("table output disagrees with code");

        input_path_a: assert property (
            (!$past(i_reset) && $stable(sel_a[t])
                && $past(sel_a[t], 2) == sel_a[t])
                |-> tab_a[t] == $past(i_cmp[sel_a[t]], 2))
            else $error("input A not two cycles behind comparator");

        input_b_path_a: assert property (
            (!$past(i_reset) && $stable(sel_b[t])
                && $past(sel_b[t], 2) == sel_b[t])
                |-> tab_b[t] == $past(i_cmp[sel_b[t]], 2))
            else $error("input B not two cycles behind comparator");

        single_codes_a: assert property (
            (func[t] == cltab_pkg::FN_A |-> o_dsi[t] == tab_a[t])
                and (func[t] == cltab_pkg::FN_B |-> o_dsi[t] == tab_b[t])
                and (func[t] == cltab_pkg::FN_NOT_B
                |-> o_dsi[t] != tab_b[t]))
            else $error("single-input code wrong");

        parity_codes_a: assert property (
            (func[t] == cltab_pkg::FN_XOR
                |-> o_dsi[t] == (tab_a[t] ^ tab_b[t]))
                and (func[t] == cltab_pkg::FN_XNOR
                |-> o_dsi[t] == (tab_a[t] == tab_b[t]))
                and (func[t] == cltab_pkg::FN_NOR
                |-> o_dsi[t] == !(tab_a[t] || tab_b[t])))
            else $error("or-type or parity code wrong");

        dsi_copy_a: assert property (
            o_dsi[t] == func[t][{~cmp_sync[sel_a[t]], ~cmp_sync[sel_b[t]]}])
            else $error("interface does not carry table output");
    end

    for (genvar d = 0; d < ND; d++) begin : g_chk_route
        route_path_a: assert property (
            (i_route_we && i_route_dest == 2'(d)) ##1 $stable(o_dsi)
                |-> o_route[d] == ($past(i_route_en)
                && o_dsi[$past(i_route_table)]))
            else $error("routed output does not follow table");

        route_off_a: assert property (
            (i_route_we && i_route_dest == 2'(d) && !i_route_en)
                |=> !o_route[d])
            else $error("disabled destination still driven");

        route_hold_a: assert property (
            (i_route_we && i_route_dest != 2'(d))
                |=> $stable(route_en[d]) && $stable(route_table[d]))
            else $error("routing write disturbed another slot");
    end

    route_reset_a: assert property (
        $past(i_reset) |-> o_route == '0)
        else $error("destination enabled after reset");

    two_cmp_c: cover property (
        i_cfg_we && i_cfg_sel_a != i_cfg_sel_b ##1 o_dsi != '0);
    xor_c: cover property (
        func[0] == cltab_pkg::FN_XOR && o_dsi[0]);
    route_irq_c: cover property (
        o_route[cltab_pkg::DEST_IRQ] ##1 !o_route[cltab_pkg::DEST_IRQ]);
    not_a_c: cover property (
        func[3] == cltab_pkg::FN_NOT_A && o_dsi[3]);
    route_two_c: cover property (
        route_en[0] && route_en[3] && route_table[0] != route_table[3]);
endmodule : cltab_array
`default_nettype wire

// ==== dv/cltab_cmp_model.sv ====
/*
 * Comparator bank model feeding the logic table array.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cltab_cmp_model (
    input wire logic i_core_clk,    // system clock
    input wire logic [3:0] i_level, // wanted levels
    output logic [3:0] o_cmp        // comparator outs
);
    // comparators as sources
    // moves off the edge, since real comparators are asynchronous
    always @(posedge i_core_clk) begin
        o_cmp <= #1 i_level;
    end
endmodule : cltab_cmp_model
`default_nettype wire

// ==== dv/cltab_array_test.sv ====
/*
 * Bench for the comparator logic table array: reset, codes, routing.
 * Assumes the comparator model and a 2-cycle input synchronizer.
 */
`timescale 1ns/1ps
`default_nettype none
module cltab_array_test;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] pat = 4'h0;
    logic [3:0] i_cmp;
    logic i_cfg_we = 1'b0;
    logic [1:0] i_cfg_idx = 2'h0;
    logic [3:0] i_cfg_func = 4'h0;
    logic [1:0] i_cfg_sel_a = 2'h0;
    logic [1:0] i_cfg_sel_b = 2'h0;
    logic i_route_we = 1'b0;
    logic [1:0] i_route_dest = 2'h0;
    logic [1:0] i_route_table = 2'h0;
    logic i_route_en = 1'b0;
    logic [3:0] o_dsi;
    logic [3:0] o_route;
    logic [15:0] o_func_words;
    logic [3:0] e;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    cltab_cmp_model i_cltab_cmp_model (.i_core_clk(i_core_clk),
        .i_level(pat), .o_cmp(i_cmp));
    cltab_array i_cltab_array (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_cmp(i_cmp), .i_cfg_we(i_cfg_we), .i_cfg_idx(i_cfg_idx),
        .i_cfg_func(i_cfg_func), .i_cfg_sel_a(i_cfg_sel_a),
        .i_cfg_sel_b(i_cfg_sel_b), .i_route_we(i_route_we),
        .i_route_dest(i_route_dest), .i_route_table(i_route_table),
        .i_route_en(i_route_en), .o_dsi(o_dsi), .o_route(o_route),
        .o_func_words(o_func_words));
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cfg(input logic [1:0] t, input logic [3:0] fn,
                       input logic [1:0] sa, input logic [1:0] sb);
        i_cfg_idx = t;
        i_cfg_func = fn;
        i_cfg_sel_a = sa;
        i_cfg_sel_b = sb;
        i_cfg_we = 1'b1;
        tick(1);
        i_cfg_we = 1'b0;
        tick(1);
    endtask : cfg
    task automatic route(input logic [1:0] d, input logic [1:0] t,
                         input logic en);
        i_route_dest = d;
        i_route_table = t;
        i_route_en = en;
        i_route_we = 1'b1;
        tick(1);
        i_route_we = 1'b0;
        tick(1);
    endtask : route
    task automatic reset_values();
        pat = 4'hF;
        tick(4);
        check("dsi", 16'h0, {12'h0, o_dsi});
        check("route", 16'h0, {12'h0, o_route});
        check("words", 16'h0, o_func_words);
    endtask : reset_values
    task automatic all_codes();
        for (int c = 0; c < 16; c++) begin
            cfg(2'h0, c[3:0], 2'h0, 2'h1);
            check("word0", c, {12'h0, o_func_words[3:0]});
            for (int ab = 0; ab < 4; ab++) begin
                pat = {2'h0, ab[1], ab[0]};
                tick(4);
                e[0] = c[{~ab[0], ~ab[1]}];
                check("code", {12'h0, e[0]}, {15'h0, o_dsi[0]});
            end
        end
    endtask : all_codes
    task automatic tables_and_routes();
        for (int t = 0; t < 3; t++) begin
            cfg(t[1:0], cltab_pkg::FN_A, t[1:0], t[1:0]);
        end
        cfg(2'h3, cltab_pkg::FN_NOT_A, 2'h3, 2'h3);
        check("words", 16'hC333, o_func_words);
        pat = 4'h5;
        tick(4);
        e = {~pat[3], pat[2:0]};
        check("dsi", {12'h0, e}, {12'h0, o_dsi});
        for (int d = 0; d < 4; d++) begin
            route(d[1:0], 2'(3 - d), 1'b1);
        end
        check("route", {12'h0, e[0], e[1], e[2], e[3]},
              {12'h0, o_route});
        route(2'h0, 2'h3, 1'b0);
        check("route off", {12'h0, e[0], e[1], e[2], 1'b0},
              {12'h0, o_route});
    endtask : tables_and_routes
    task automatic mid_reset();
        i_reset = 1'b1;
        tick(2);
        i_reset = 1'b0;
        check("words", 16'h0, o_func_words);
        check("dsi", 16'h0, {12'h0, o_dsi});
        check("route", 16'h0, {12'h0, o_route});
        tick(1);
        cfg(2'h1, cltab_pkg::FN_TRUE, 2'h0, 2'h0);
        check("dsi", 16'h2, {12'h0, o_dsi});
    endtask : mid_reset
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // ceiling well above the roughly 320 cycles the tests need
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        tick(4);
        i_reset = 1'b0;
        reset_values();
        all_codes();
        tables_and_routes();
        mid_reset();
        end_of_test();
    end
endmodule : cltab_array_test
`default_nettype wire
